// File: rtl/scs_map.svh
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Reference clock rate in MHz.
`define SCS_CLK_MHZ        40
// Watchdog timeout in nanoseconds, as a longest time it rounds down.
`define SCS_WDOG_NS        12800
`define SCS_WDOG_CYC       ((`SCS_WDOG_NS * `SCS_CLK_MHZ) / 1000)
// Width of the watchdog counter.
`define SCS_WDOG_W         10
// Internal register address width and its split.
`define SCS_ADDR_W         12
`define SCS_ADDR_HI_MSB    11
`define SCS_ADDR_HI_LSB    8
`define SCS_ADDR_LO_MSB    7
// Addressing byte fields.
`define SCS_ID_MSB         7
`define SCS_ID_LSB         5
`define SCS_AHI_MSB        4
`define SCS_AHI_LSB        1
`define SCS_RW_BIT         0
// All-ones identifier answered by every slave.
`define SCS_BCAST_ID       3'h7
// Reset values.
// Bus lines idle high, so their edge history resets to that level.
`define SCS_LINE_IDLE      3'h7
`define SCS_ADDR_RST       12'h000
`define SCS_BYTE_RST       8'h00
`define SCS_BIT_LAST       3'h7
`define SCS_BIT_RST        3'h0

`endif

// File: rtl/scs_pkg.sv
package scs_pkg;

	// Slave sequencer states.
	typedef enum logic [3:0] {
		SCS_IDLE,
		SCS_ADDR,
		SCS_ADDR_ACK,
		SCS_WR_BYTE,
		SCS_WR_ACK,
		SCS_RD_LOAD,
		SCS_RD_BYTE,
		SCS_RD_ACK,
		SCS_SKIP
	} scs_state_e;

endpackage : scs_pkg

// File: rtl/scs_slave.sv
// Function
// - Everything runs on reference clock; lines sampled.
// - Watchdog restarts per falling edge, 12.8 us timeout.
// - Watchdog armed at first fall, stopped by stop.
// - Address split: four in addressing byte, eight next.
// - Upper address bits taken only on writes.
// - Address counter advances after each data acknowledge.
// - Answer to strapped chip identifier.
// - Answer broadcast identifier; master never reads broadcast.
// - Direction may change after repeated start.
// - Reads start at current address counter.
// - All flip-flops use asynchronous reset only.
// - Flip-flops reset to zero or documented defaults.
// - Reset asserts asynchronously, releases through synchronizer.
`include "scs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_slave #(
	parameter int WDOG_CYC = `SCS_WDOG_CYC
) (
	input  wire logic                     i_ref_clk,             // Reference clock.
	input  wire logic                     i_rstn,                // Active-low reset pin.
	input  wire logic                     i_scl,                 // Bus serial clock pin.
	input  wire logic                     i_sda_in,              // Bus data pin level.
	output logic                          o_sda_out,             // Bus data drive value.
	output logic                          o_sda_oe,              // High while pulling data low.
	input  wire logic [2:0]               i_chip_select_straps,  // Strapped identifier pins.
	output logic [`SCS_ADDR_W-1:0]        o_reg_addr,            // Current register address.
	output logic [7:0]                    o_reg_wdata,           // Write data byte.
	output logic                          o_reg_wr,              // One-cycle write strobe.
	input  wire logic [7:0]               i_reg_rdata            // Read data at o_reg_addr.
);

	// Refuse a watchdog too short to separate two edges or too wide for its counter.
	if (WDOG_CYC < 2 || WDOG_CYC >= (1 << `SCS_WDOG_W)) begin : g_chk
		$error("WDOG_CYC out of range");
	end

	logic [1:0]               rst_sync_ff;     // Reset release synchronizer.
	logic                     rst_n;           // Internal reset for all logic after the synchronizer.
	logic [2:0]               scl_sync_ff;     // Serial clock sync plus history.
	logic [2:0]               sda_sync_ff;     // Serial data sync plus history.
	logic [2:0]               id_meta_ff;      // Strap synchronizer first stage.
	logic [2:0]               id_ff;           // Strap synchronizer second stage.
	scs_pkg::scs_state_e      state_ff;        // Sequencer state.
	logic [2:0]               bit_ff;          // Bit position within a byte.
	logic [7:0]               shift_ff;        // Receive and transmit shifter.
	logic                     first_ff;        // Next write byte is the low address.
	logic                     full_ff;         // All eight bits of the byte are in.
	logic                     nack_ff;         // Master declined the last read byte.
	logic                     wdog_on_ff;      // Watchdog armed.
	logic [`SCS_WDOG_W-1:0]   wdog_cnt_ff;     // Cycles since last falling edge.
	logic [`SCS_ADDR_W-1:0]   addr_ff;         // Address counter.
	logic [7:0]               wdata_ff;        // Write data register.
	logic                     wr_ff;           // Write strobe register.
	logic                     sda_oe_ff;       // Data line pull-down enable.
	logic                     sda_out_ff;      // Constant low drive value.
	logic                     scl_rise;        // Serial clock rose.
	logic                     scl_fall;        // Serial clock fell.
	logic                     start_det;       // Data fell while clock high.
	logic                     stop_det;        // Data rose while clock high.
	logic                     wdog_trip;       // Watchdog timeout reached.
	logic                     id_match;        // Addressing byte selects us.
	logic [7:0]               rx_byte;         // Byte including the bit just sampled.

	// The pin reset clears asynchronously; release waits two clock edges so that
	// no flip-flop sees its reset removed close to a clock edge.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Bus lines are plain inputs: two flops to synchronize, a third for edges.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_ff <= `SCS_LINE_IDLE;
			sda_sync_ff <= `SCS_LINE_IDLE;
		end else begin
			scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
			sda_sync_ff <= {sda_sync_ff[1:0], i_sda_in};
		end
	end

	// Straps are static but still come from pins, so they are synchronized too.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_meta_ff <= 3'h0;
			id_ff      <= 3'h0;
		end else begin
			id_meta_ff <= i_chip_select_straps;
			id_ff      <= id_meta_ff;
		end
	end

	// Edge and condition detection works on the synchronized copies only.
	assign scl_rise  = scl_sync_ff[1] & ~scl_sync_ff[2];
	assign scl_fall  = ~scl_sync_ff[1] & scl_sync_ff[2];
	assign start_det = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
	assign stop_det  = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];
	assign wdog_trip = wdog_on_ff && (wdog_cnt_ff >= WDOG_CYC[`SCS_WDOG_W-1:0]);
	assign rx_byte   = {shift_ff[6:0], sda_sync_ff[1]};
	assign id_match  = (shift_ff[`SCS_ID_MSB:`SCS_ID_LSB] == id_ff) ||
	                   (shift_ff[`SCS_ID_MSB:`SCS_ID_LSB] == `SCS_BCAST_ID);

	// Watchdog: armed by the first falling edge of a frame, restarted by every
	// falling edge, disarmed by a stop or by its own timeout. A master slower
	// than the timeout is therefore cut off mid-frame.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_on_ff  <= 1'b0;
			wdog_cnt_ff <= '0;
		end else if (stop_det || wdog_trip) begin
			wdog_on_ff  <= 1'b0;
			wdog_cnt_ff <= '0;
		end else if (scl_fall && state_ff != scs_pkg::SCS_IDLE) begin
			wdog_on_ff  <= 1'b1;
			wdog_cnt_ff <= '0;
		end else if (wdog_on_ff) begin
			wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
		end
	end

	// Bit counter and shifter: data is sampled on rising clock edges and,
	// while reading, the next bit is presented after each falling edge.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_ff   <= `SCS_BIT_RST;
			shift_ff <= `SCS_BYTE_RST;
			full_ff  <= 1'b0;
		end else if (start_det) begin
			bit_ff  <= `SCS_BIT_RST;
			full_ff <= 1'b0;
		end else begin
			case (state_ff)
				// The bit counter alone cannot tell a full byte from the falling
				// edge that closes a start, so the eighth rise is remembered.
				scs_pkg::SCS_ADDR, scs_pkg::SCS_WR_BYTE: begin
					if (scl_rise) begin
						shift_ff <= rx_byte;
						bit_ff   <= bit_ff + 1'b1;
						full_ff  <= (bit_ff == `SCS_BIT_LAST);
					end
				end
				scs_pkg::SCS_RD_LOAD: begin
					shift_ff <= i_reg_rdata;
					bit_ff   <= `SCS_BIT_RST;
				end
				scs_pkg::SCS_RD_BYTE: begin
					if (scl_fall) begin
						shift_ff <= {shift_ff[6:0], 1'b0};
						bit_ff   <= bit_ff + 1'b1;
					end
				end
				default: begin
					bit_ff  <= `SCS_BIT_RST;
					full_ff <= 1'b0;
				end
			endcase
		end
	end

	// Sequencer. Start wins over every state so a repeated start can turn the
	// direction round inside one frame; stop and timeout win even over start and return to idle.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= scs_pkg::SCS_IDLE;
			first_ff <= 1'b0;
			nack_ff  <= 1'b0;
		end else if (wdog_trip || stop_det) begin
			state_ff <= scs_pkg::SCS_IDLE;
		end else if (start_det) begin
			state_ff <= scs_pkg::SCS_ADDR;
		end else begin
			case (state_ff)
				scs_pkg::SCS_IDLE: begin
					state_ff <= scs_pkg::SCS_IDLE;
				end
				scs_pkg::SCS_ADDR: begin
					// After the eighth bit, the falling edge opens the acknowledge slot.
					if (scl_fall && full_ff) begin
						if (id_match) begin
							state_ff <= scs_pkg::SCS_ADDR_ACK;
							first_ff <= ~shift_ff[`SCS_RW_BIT];
						end else begin
							state_ff <= scs_pkg::SCS_SKIP;
						end
					end
				end
				scs_pkg::SCS_ADDR_ACK: begin
					if (scl_fall) begin
						state_ff <= shift_ff[`SCS_RW_BIT] ? scs_pkg::SCS_RD_LOAD
						                                  : scs_pkg::SCS_WR_BYTE;
					end
				end
				scs_pkg::SCS_WR_BYTE: begin
					if (scl_fall && full_ff) begin
						state_ff <= scs_pkg::SCS_WR_ACK;
					end
				end
				scs_pkg::SCS_WR_ACK: begin
					if (scl_fall) begin
						state_ff <= scs_pkg::SCS_WR_BYTE;
						first_ff <= 1'b0;
					end
				end
				scs_pkg::SCS_RD_LOAD: begin
					state_ff <= scs_pkg::SCS_RD_BYTE;
				end
				scs_pkg::SCS_RD_BYTE: begin
					if (scl_fall && bit_ff == `SCS_BIT_LAST) begin
						state_ff <= scs_pkg::SCS_RD_ACK;
					end
				end
				scs_pkg::SCS_RD_ACK: begin
					if (scl_rise) begin
						nack_ff <= sda_sync_ff[1];
					end
					// A declined byte ends the read; the master then stops or restarts.
					if (scl_fall) begin
						state_ff <= nack_ff ? scs_pkg::SCS_SKIP : scs_pkg::SCS_RD_LOAD;
						nack_ff  <= 1'b0;
					end
				end
				scs_pkg::SCS_SKIP: begin
					state_ff <= scs_pkg::SCS_SKIP;
				end
				default: begin
					state_ff <= scs_pkg::SCS_IDLE;
				end
			endcase
		end
	end

	// Address counter and write port. The low address byte and the data bytes
	// are both taken in the first cycle of our acknowledge, when the pull-down
	// starts, so the strobe never runs ahead of the acknowledge.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff  <= `SCS_ADDR_RST;
			wdata_ff <= `SCS_BYTE_RST;
			wr_ff    <= 1'b0;
		end else begin
			wr_ff <= 1'b0;
			if (state_ff == scs_pkg::SCS_ADDR && scl_fall && full_ff &&
			    id_match && !shift_ff[`SCS_RW_BIT]) begin
				addr_ff[`SCS_ADDR_HI_MSB:`SCS_ADDR_HI_LSB] <=
					shift_ff[`SCS_AHI_MSB:`SCS_AHI_LSB];
			end else if (state_ff == scs_pkg::SCS_WR_ACK && !sda_oe_ff) begin
				if (first_ff) begin
					addr_ff[`SCS_ADDR_LO_MSB:0] <= shift_ff;
				end else begin
					wdata_ff <= shift_ff;
					wr_ff    <= 1'b1;
				end
			end else if (state_ff == scs_pkg::SCS_WR_ACK && scl_fall && !first_ff) begin
				addr_ff <= addr_ff + 1'b1;
			end else if (state_ff == scs_pkg::SCS_RD_ACK && scl_fall) begin
				addr_ff <= addr_ff + 1'b1;
			end
		end
	end

	// Data line drive: pulled low for our acknowledges and for zero read bits.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_oe_ff  <= 1'b0;
			sda_out_ff <= 1'b0;
		end else begin
			sda_out_ff <= 1'b0;
			case (state_ff)
				scs_pkg::SCS_ADDR_ACK, scs_pkg::SCS_WR_ACK: begin
					sda_oe_ff <= 1'b1;
				end
				scs_pkg::SCS_RD_BYTE: begin
					sda_oe_ff <= ~shift_ff[7];
				end
				default: begin
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	assign o_sda_out   = sda_out_ff;
	assign o_sda_oe    = sda_oe_ff;
	assign o_reg_addr  = addr_ff;
	assign o_reg_wdata = wdata_ff;
	assign o_reg_wr    = wr_ff;

endmodule : scs_slave

`default_nettype wire

// File: testbench/scs_slave_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Timing checks on the slave ports; all of it lives in the reference clock domain.
module scs_slave_chk #(
	parameter int WDOG_CYC = 512
) (
	input wire logic        i_ref_clk,   // Reference clock.
	input wire logic        i_rstn,      // Active-low reset pin.
	input wire logic        i_scl,       // Bus clock level.
	input wire logic        i_sda_in,    // Bus data level.
	input wire logic        o_sda_out,   // Data drive value.
	input wire logic        o_sda_oe,    // Data pull enable.
	input wire logic [11:0] o_reg_addr,  // Address counter.
	input wire logic        o_reg_wr     // Write strobe.
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	logic        scl_ff;   // Bus clock one cycle ago.
	logic [10:0] idle_ff;  // Cycles since the last bus clock fall, saturating.

	// Keep the previous bus clock level for fall detection.
	always_ff @(posedge i_ref_clk) begin
		scl_ff <= i_scl;
	end

	// Saturate so a long idle bus cannot wrap back into a small count.
	always_ff @(posedge i_ref_clk) begin
		if (scl_ff && !i_scl) begin
			idle_ff <= 11'h000;
		end else if (idle_ff != 11'h7ff) begin
			idle_ff <= idle_ff + 11'h001;
		end
	end

	property p_out_low;
		o_sda_out == 1'b0;
	endproperty
	a_out_low: assert property (p_out_low) else $error("drive value not low");
	property p_wr_pulse;
		o_reg_wr |=> !o_reg_wr [*8];
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("strobe too long");
	property p_wr_ack;
		o_reg_wr |-> o_sda_oe;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("strobe without ack");
	property p_wr_hold;
		o_reg_wr |=> $stable(o_reg_addr) [*2];
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("address moved at strobe");
	property p_addr_low;
		$changed(o_reg_addr) |-> !i_scl;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("address moved in high");
	property p_oe_low;
		$changed(o_sda_oe) |-> !i_scl;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("data moved in high");
	property p_wdog;
		idle_ff > WDOG_CYC + 8 |-> !o_sda_oe;
	endproperty
	a_wdog: assert property (p_wdog) else $error("line held past timeout");
	property p_stop;
		i_scl && $past(i_scl) && $rose(i_sda_in) |-> ##4 !o_sda_oe;
	endproperty
	a_stop: assert property (p_stop) else $error("line held after stop");
endmodule : scs_slave_chk

bind scs_slave scs_slave_chk #(.WDOG_CYC(WDOG_CYC)) i_chk (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda_in(i_sda_in),
	.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr));
`default_nettype wire

// File: testbench/scs_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// Control-side bus master; it only pulls data low, the pull-up gives the high level.
module scs_bus_master (
	input  wire logic i_clk,     // Reference clock.
	input  wire logic i_sda,     // Resolved data wire.
	output var logic  o_scl,     // Bus clock.
	output var logic  o_sda_oe   // High while pulling data low.
);
	// Bit time is three half steps, well above the lowest allowed rate.
	localparam int HALF = 10;

	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	// One half step of the bus clock.
	task automatic hp;
		repeat (HALF) @(posedge i_clk);
	endtask : hp

	// Start, also usable as a repeated start from a low clock.
	task automatic start;
		o_sda_oe <= 1'b0;
		hp();
		o_scl <= 1'b1;
		hp();
		o_sda_oe <= 1'b1;
		hp();
		o_scl <= 1'b0;
		hp();
	endtask : start

	// Nine bits MSB first; data moves only while the clock is low.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			o_sda_oe <= !d[i];
			hp();
			o_scl <= 1'b1;
			hp();
			q[i] = i_sda;
			o_scl <= 1'b0;
			hp();
		end
	endtask : xfer

	// Stop ends the frame and leaves both lines high.
	task automatic stop;
		o_sda_oe <= 1'b1;
		hp();
		o_scl <= 1'b1;
		hp();
		o_sda_oe <= 1'b0;
		hp();
	endtask : stop
endmodule : scs_bus_master
`default_nettype wire

// File: testbench/scs_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none
module scs_slave_bench;
	logic        ref_clk, rstn, scl, mst_oe, dut_oe, sda_out, wr;
	logic [2:0]  straps;       // Strapped identifier.
	logic [11:0] addr;         // Slave address counter.
	logic [7:0]  wdata, rdata; // Register data both ways.
	logic [7:0]  mem [4096];   // Register file behind the slave.
	logic [8:0]  q;            // Bits seen by the master.
	wire logic   sda;          // Open-drain wire with pull-up.
	int          fail_count, checks_done;

	assign sda = !(mst_oe || dut_oe);
	assign rdata = mem[addr];

	scs_slave #(.WDOG_CYC(100)) i_dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_scl(scl),
		.i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(dut_oe),
		.i_chip_select_straps(straps), .o_reg_addr(addr), .o_reg_wdata(wdata),
		.o_reg_wr(wr), .i_reg_rdata(rdata));
	scs_bus_master i_mst (.i_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(mst_oe));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Register file store on the one-cycle strobe.
	always @(posedge ref_clk) begin
		if (wr === 1'b1) mem[addr] <= wdata;
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Write a byte and judge the acknowledge level.
	task automatic wb(input logic [7:0] d, input logic nack);
		i_mst.xfer({d, 1'b1}, q);
		chk({11'h000, q[0]}, {11'h000, nack});
	endtask : wb

	// Read a byte, then acknowledge or refuse it.
	task automatic rb(input logic [7:0] exp, input logic nack);
		i_mst.xfer({8'hff, nack}, q);
		chk({4'h0, q[8:1]}, {4'h0, exp});
	endtask : rb

	task automatic t_burst;
		i_mst.start();
		wb({3'h3, 4'h0, 1'b0}, 1'b0);
		wb(8'h02, 1'b0);
		wb(8'hfa, 1'b0);
		wb(8'h0b, 1'b0);
		i_mst.stop();
		chk({4'h0, mem[12'h002]}, 12'h0fa);
		chk({4'h0, mem[12'h003]}, 12'h00b);
		chk(addr, 12'h004);
		$display("burst write done");
	endtask : t_burst

	// Upper bits in a read addressing byte must be ignored.
	task automatic t_read;
		i_mst.start();
		wb({3'h3, 4'hf, 1'b1}, 1'b0);
		rb(8'h04, 1'b0);
		chk(addr, 12'h005);
		rb(8'h05, 1'b1);
		i_mst.stop();
		$display("current read done");
	endtask : t_read

	task automatic t_mixed;
		i_mst.start();
		wb({3'h3, 4'h1, 1'b0}, 1'b0);
		wb(8'h23, 1'b0);
		i_mst.start();
		wb({3'h3, 4'h0, 1'b1}, 1'b0);
		rb(8'h31, 1'b1);
		i_mst.stop();
		$display("mixed transfer done");
	endtask : t_mixed

	// Broadcast writes land; a foreign identifier is ignored whole.
	task automatic t_ids;
		i_mst.start();
		wb({3'h7, 4'h2, 1'b0}, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'h99, 1'b0);
		i_mst.stop();
		chk({4'h0, mem[12'h200]}, 12'h099);
		i_mst.start();
		wb({3'h5, 4'h3, 1'b0}, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h66, 1'b1);
		i_mst.stop();
		chk({4'h0, mem[12'h300]}, 12'h030);
		chk(addr, 12'h201);
		$display("identifier test done");
	endtask : t_ids

	// A stalled clock past the timeout drops the frame.
	task automatic t_wdog;
		i_mst.start();
		wb({3'h3, 4'h4, 1'b0}, 1'b0);
		repeat (150) @(posedge ref_clk);
		wb(8'h10, 1'b1);
		wb(8'h77, 1'b1);
		i_mst.stop();
		chk({4'h0, mem[12'h410]}, 12'h051);
		chk(addr, 12'h401);
		$display("watchdog test done");
	endtask : t_wdog

	// The address is looked at before the next clock edge to show reset acts at once.
	task automatic t_reset;
		@(posedge ref_clk);
		rstn <= 1'b0;
		#1 chk(addr, 12'h000);
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk({10'h000, dut_oe, wr}, 12'h000);
		$display("reset test done");
	endtask : t_reset

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		rstn = 1'b0;
		straps = 3'h3;
		for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'(i >> 4);
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		t_burst();
		t_read();
		t_mixed();
		t_ids();
		t_wdog();
		t_reset();
		give_verdict();
	end

	// The tests need about six thousand cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
endmodule : scs_slave_bench
`default_nettype wire
